// ---- rtl/eac_pkg.sv ----
/*
 * eac_pkg: constants, register map and carrier types of the event action configuration bank.
 * assumes: a single 125 MHz clock domain; one 32-bit Avalon-MM word per register.
 */
package eac_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned QTR_MS = 250;
  localparam int unsigned QTR_CYC = CLK_HZ / MS_PER_S * QTR_MS;

  // widths
  localparam int CODE_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ST_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_INPUT_THREE_ACT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BOOT_ACT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_JOIN_ACT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TMR0_THR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TMR0_ACT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TMR0_CNT = 8'h1C;

  // reset values
  localparam logic [CODE_W-1:0] RST_INTERRUPT_INPUT_THREE_ACT = 16'h0000;
  localparam logic [CODE_W-1:0] RST_BOOT_ACT = 16'h0000;
  localparam logic [CODE_W-1:0] RST_JOIN_ACT = 16'h0000;
  localparam logic [CODE_W-1:0] RST_TMR0_THR = 16'h0004;
  localparam logic [CODE_W-1:0] RST_TMR0_ACT = 16'h8010;
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  localparam logic [ST_W-1:0] RST_MASK = 4'h0;

  // status and mask bit positions, also the action priority (lowest first)
  localparam int ST_INTERRUPT_INPUT_THREE = 0;
  localparam int ST_BOOT = 1;
  localparam int ST_JOIN = 2;
  localparam int ST_TMR0 = 3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef enum logic [1:0] {
    SRC_INTERRUPT_INPUT_THREE = 2'b00,
    SRC_BOOT = 2'b01,
    SRC_JOIN = 2'b11,
    SRC_TMR0 = 2'b10
  } eac_src_t;

  typedef struct packed {
    logic [CODE_W-1:0] interrupt_input_three_action_code;
    logic [CODE_W-1:0] boot_action_code;
    logic [CODE_W-1:0] join_action_code;
    logic [CODE_W-1:0] timer0_threshold;
    logic [CODE_W-1:0] timer0_action_code;
  } eac_cfg_t;

  typedef struct packed {
    eac_src_t src;
    logic [CODE_W-1:0] code;
  } eac_action_t;

endpackage : eac_pkg

// ---- rtl/eac_tick.sv ----
/*
 * eac_tick: divider giving a one-cycle enable pulse every DIV clock cycles.
 * assumes: synchronous reset copy from the parent; restart realigns the phase.
 */
`timescale 1ns/1ps
module eac_tick #(
  parameter int unsigned DIV = eac_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic restart,
  // output
  output logic tick
);
  import eac_pkg::*;

  logic [31:0] div_q;
  logic tick_q;
  localparam logic [31:0] DIV_LAST = 32'(DIV - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (!enable || restart) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule : eac_tick

// ---- rtl/eac_bank.sv ----
/*
 * eac_bank: event action configuration bank with timer/counter 0, action issue,
 * interrupt status and a non-volatile mirror port.
 * assumes: boot_stack_ready and network_joined are one-cycle pulses on ref_clk;
 * port_b_pin_six is asynchronous; the nv store keeps what nv_store_data shows.
 */
`timescale 1ns/1ps
module eac_bank #(
  parameter int unsigned QTR_CYCLES = eac_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [eac_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [eac_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [eac_pkg::BE_W-1:0] avs_byteenable,
  output logic [eac_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // events
  input wire logic port_b_pin_six,
  input wire logic boot_stack_ready,
  input wire logic network_joined,
  // actions
  output eac_pkg::eac_action_t action,
  output logic action_valid,
  // non-volatile mirror
  input wire logic nv_restore_valid,
  input eac_pkg::eac_cfg_t nv_restore_data,
  output logic nv_store_valid,
  output eac_pkg::eac_cfg_t nv_store_data,
  // interrupt
  output logic irq
);
  import eac_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic [CODE_W-1:0] merge(input logic [CODE_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [BE_W-1:0] be);
    merge = old;
    if (be[0]) merge[7:0] = wd[7:0];
    if (be[1]) merge[15:8] = wd[15:8];
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon handshake: waitrequest drops for one cycle per request
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic req;
  logic acc_wr;

  assign req = avs_read || avs_write;
  assign acc_wr = avs_write && !wait_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  eac_cfg_t cfg_q;
  logic nv_store_q;
  logic cfg_wr;
  logic thr_wr;

  assign cfg_wr = acc_wr && (hit(avs_address, OFF_INTERRUPT_INPUT_THREE_ACT) || hit(avs_address, OFF_BOOT_ACT) ||
                             hit(avs_address, OFF_JOIN_ACT) || hit(avs_address, OFF_TMR0_THR) ||
                             hit(avs_address, OFF_TMR0_ACT));
  assign thr_wr = (acc_wr && hit(avs_address, OFF_TMR0_THR)) || nv_restore_valid;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q.interrupt_input_three_action_code <= RST_INTERRUPT_INPUT_THREE_ACT;
      cfg_q.boot_action_code <= RST_BOOT_ACT;
      cfg_q.join_action_code <= RST_JOIN_ACT;
      cfg_q.timer0_threshold <= RST_TMR0_THR;
      cfg_q.timer0_action_code <= RST_TMR0_ACT;
    end else if (nv_restore_valid) begin
      cfg_q <= nv_restore_data;
    end else if (acc_wr) begin
      if (hit(avs_address, OFF_INTERRUPT_INPUT_THREE_ACT)) cfg_q.interrupt_input_three_action_code <=
        merge(cfg_q.interrupt_input_three_action_code, avs_writedata, avs_byteenable);
      if (hit(avs_address, OFF_BOOT_ACT)) cfg_q.boot_action_code <=
        merge(cfg_q.boot_action_code, avs_writedata, avs_byteenable);
      if (hit(avs_address, OFF_JOIN_ACT)) cfg_q.join_action_code <=
        merge(cfg_q.join_action_code, avs_writedata, avs_byteenable);
      if (hit(avs_address, OFF_TMR0_THR)) cfg_q.timer0_threshold <=
        merge(cfg_q.timer0_threshold, avs_writedata, avs_byteenable);
      if (hit(avs_address, OFF_TMR0_ACT)) cfg_q.timer0_action_code <=
        merge(cfg_q.timer0_action_code, avs_writedata, avs_byteenable);
    end
  end

  // store request follows every bus write of a configuration register, except one in the same cycle as nv_restore_valid
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nv_store_q <= 1'b0;
    end else begin
      nv_store_q <= cfg_wr && !nv_restore_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer/counter 0
  logic qtr_tick;
  logic [CODE_W-1:0] cnt_q;
  logic thr_on;
  logic tmr_ev;

  assign thr_on = (cfg_q.timer0_threshold != CODE_NONE);

  eac_tick #(
    .DIV(QTR_CYCLES)
  ) u_tick (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .enable(thr_on),
    .restart(thr_wr),
    .tick(qtr_tick)
  );

  assign tmr_ev = qtr_tick && thr_on && (cnt_q == cfg_q.timer0_threshold - 16'h0001);

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= 16'h0000;
    end else if (!thr_on || thr_wr) begin
      cnt_q <= 16'h0000;
    end else if (tmr_ev) begin
      cnt_q <= 16'h0000;
    end else if (qtr_tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event sources
  logic interrupt_input_three_meta_q;
  logic interrupt_input_three_sync_q;
  logic interrupt_input_three_prev_q;
  logic boot_done_q;
  logic [ST_W-1:0] ev;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      interrupt_input_three_meta_q <= 1'b0;
      interrupt_input_three_sync_q <= 1'b0;
      interrupt_input_three_prev_q <= 1'b0;
    end else begin
      interrupt_input_three_meta_q <= port_b_pin_six;
      interrupt_input_three_sync_q <= interrupt_input_three_meta_q;
      interrupt_input_three_prev_q <= interrupt_input_three_sync_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      boot_done_q <= 1'b0;
    end else if (boot_stack_ready) begin
      boot_done_q <= 1'b1;
    end
  end

  always_comb begin
    ev = '0;
    ev[ST_INTERRUPT_INPUT_THREE] = interrupt_input_three_sync_q && !interrupt_input_three_prev_q;
    ev[ST_BOOT] = boot_stack_ready && !boot_done_q;
    ev[ST_JOIN] = network_joined;
    ev[ST_TMR0] = tmr_ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // action issue: pending events served one per cycle, lowest index first
  logic [ST_W-1:0] pend_q;
  logic [ST_W-1:0] grant;
  logic [CODE_W-1:0] g_code;
  eac_src_t g_src;
  eac_action_t act_q;
  logic act_vld_q;

  always_comb begin
    grant = '0;
    for (int i = ST_W - 1; i >= 0; i--) begin
      if (pend_q[i]) grant = ST_W'(1) << i;
    end
  end

  always_comb begin
    g_code = CODE_NONE;
    g_src = SRC_INTERRUPT_INPUT_THREE;
    unique case (1'b1)
      grant[ST_INTERRUPT_INPUT_THREE]: begin
        g_code = cfg_q.interrupt_input_three_action_code;
        g_src = SRC_INTERRUPT_INPUT_THREE;
      end
      grant[ST_BOOT]: begin
        g_code = cfg_q.boot_action_code;
        g_src = SRC_BOOT;
      end
      grant[ST_JOIN]: begin
        g_code = cfg_q.join_action_code;
        g_src = SRC_JOIN;
      end
      grant[ST_TMR0]: begin
        g_code = cfg_q.timer0_action_code;
        g_src = SRC_TMR0;
      end
      default: begin
        g_code = CODE_NONE;
        g_src = SRC_INTERRUPT_INPUT_THREE;
      end
    endcase
  end

  // a new event of a served source re-arms it in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~grant) | ev;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      act_q <= '{src: SRC_INTERRUPT_INPUT_THREE, code: CODE_NONE};
      act_vld_q <= 1'b0;
    end else begin
      act_vld_q <= (grant != '0) && (g_code != CODE_NONE);
      if (grant != '0) begin
        act_q <= '{src: g_src, code: g_code};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear, set wins) and mask
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] w1c;
  logic irq_q;

  assign w1c = (acc_wr && hit(avs_address, OFF_STATUS) && avs_byteenable[0]) ?
               avs_writedata[ST_W-1:0] : '0;

  for (genvar b = 0; b < ST_W; b++) begin : g_status
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        status_q[b] <= 1'b0;
      end else if (ev[b]) begin
        status_q[b] <= 1'b1;
      end else if (w1c[b]) begin
        status_q[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= RST_MASK;
    end else if (acc_wr && hit(avs_address, OFF_MASK) && avs_byteenable[0]) begin
      mask_q <= avs_writedata[ST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured when waitrequest drops
  always_comb begin
    rdata_d = '0;
    unique case (avs_address)
      OFF_INTERRUPT_INPUT_THREE_ACT: rdata_d[CODE_W-1:0] = cfg_q.interrupt_input_three_action_code;
      OFF_BOOT_ACT: rdata_d[CODE_W-1:0] = cfg_q.boot_action_code;
      OFF_JOIN_ACT: rdata_d[CODE_W-1:0] = cfg_q.join_action_code;
      OFF_TMR0_THR: rdata_d[CODE_W-1:0] = cfg_q.timer0_threshold;
      OFF_TMR0_ACT: rdata_d[CODE_W-1:0] = cfg_q.timer0_action_code;
      OFF_STATUS: rdata_d[ST_W-1:0] = status_q;
      OFF_MASK: rdata_d[ST_W-1:0] = mask_q;
      OFF_TMR0_CNT: rdata_d[CODE_W-1:0] = cnt_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign action = act_q;
  assign action_valid = act_vld_q;
  assign nv_store_valid = nv_store_q;
  assign nv_store_data = cfg_q;
  assign irq = irq_q;

endmodule : eac_bank

// ---- dv/eac_bank_monitor.sv ----
/* eac_bank_monitor: port assertions for eac_bank.
   assumes: bound into eac_bank, one ref_clk domain. */
`timescale 1ns/1ps
module eac_bank_monitor #(
  parameter int unsigned QTR_CYCLES = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic [eac_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [eac_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [eac_pkg::BE_W-1:0] avs_byteenable,
  input wire logic [eac_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // actions and mirror
  input wire eac_pkg::eac_action_t action,
  input wire logic action_valid,
  input wire logic nv_restore_valid,
  input wire eac_pkg::eac_cfg_t nv_restore_data,
  input wire eac_pkg::eac_cfg_t nv_store_data
);
  import eac_pkg::*;
  logic boot_seen_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_seen_q <= 1'b0;
    end else if (action_valid && action.src == SRC_BOOT) begin
      boot_seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read upper bits set");
  act_nonzero_a: assert property (action_valid |-> action.code != CODE_NONE)
    else $error("action issued with zero code");
  boot_once_a: assert property (action_valid && action.src == SRC_BOOT |-> !boot_seen_q)
    else $error("second boot action");
  thr_read_a: assert property (avs_read && !avs_waitrequest && avs_address == OFF_TMR0_THR
    |-> avs_readdata[15:0] == nv_store_data.timer0_threshold) else $error("threshold read wrong");
  thr_zero_a: assert property (action_valid && action.src == SRC_TMR0
    |-> $past(nv_store_data.timer0_threshold, 2) != 16'h0000) else $error("timer action with zero threshold");
  tmr_code_a: assert property (action_valid && action.src == SRC_TMR0
    |-> action.code == nv_store_data.timer0_action_code) else $error("timer action code wrong");
  restore_load_a: assert property (nv_restore_valid |=> nv_store_data == $past(nv_restore_data))
    else $error("restore not applied");
  join_write_a: assert property (avs_write && !avs_waitrequest && avs_address == OFF_JOIN_ACT &&
    avs_byteenable == 4'hF && !nv_restore_valid |=> nv_store_data.join_action_code == $past(avs_writedata[15:0]))
    else $error("join code write not applied");
  join_c: cover property (action_valid && action.src == SRC_JOIN);
  tmr_c: cover property (action_valid && action.src == SRC_TMR0);
  restore_c: cover property (nv_restore_valid);
endmodule : eac_bank_monitor

bind eac_bank eac_bank_monitor #(.QTR_CYCLES(QTR_CYCLES)) u_mon (.ref_clk(ref_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .action(action), .action_valid(action_valid), .nv_restore_valid(nv_restore_valid),
  .nv_restore_data(nv_restore_data), .nv_store_data(nv_store_data));

// ---- dv/eac_bank_tb_top.sv ----
/* eac_bank_tb_top: self-checking bench for eac_bank with a queue model of actions.
   assumes: eac_pkg compiled first; short quarter period for speed. */
`timescale 1ns/1ps
module eac_bank_tb_top;
  import eac_pkg::*;
  localparam int unsigned QTR = 8;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [BE_W-1:0] avs_byteenable;
  logic port_b_pin_six, boot_stack_ready, network_joined, action_valid, nv_restore_valid, nv_store_valid, irq;
  eac_action_t action;
  eac_cfg_t nv_restore_data, nv_store_data;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  bit boot_done = 0;
  logic [15:0] mdl [0:6];
  eac_action_t obs_q[$], exp_q[$];
  int t_q[$];
  eac_bank #(.QTR_CYCLES(QTR)) dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_b_pin_six(port_b_pin_six),
    .boot_stack_ready(boot_stack_ready), .network_joined(network_joined), .action(action),
    .action_valid(action_valid), .nv_restore_valid(nv_restore_valid), .nv_restore_data(nv_restore_data),
    .nv_store_valid(nv_store_valid), .nv_store_data(nv_store_data), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (action_valid === 1'b1) begin
      obs_q.push_back(action);
      t_q.push_back(cyc);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 64) begin
      fail_count++;
      summarize();
    end else begin
      @(posedge ref_clk);
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
    chk(nv_store_valid, a < OFF_STATUS, "store pulse");
    if (a != OFF_STATUS && a < 8'h1C) mdl[a[4:2]] = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e, "read");
  endtask : rd
  task automatic rd_all();
    for (int i = 0; i < 7; i++) begin
      if (i != 5) rd(8'(i * 4), {16'h0000, mdl[i]});
    end
  endtask : rd_all
  // k: 0 pin edge, 1 boot ready, 2 network join
  task automatic ev(input int k);
    eac_src_t s;
    s = (k == 0) ? SRC_INTERRUPT_INPUT_THREE : (k == 1) ? SRC_BOOT : SRC_JOIN;
    if (mdl[k] != 16'h0000 && !(k == 1 && boot_done)) exp_q.push_back({s, mdl[k]});
    if (k == 1) boot_done = 1;
    case (k)
      0: port_b_pin_six <= 1'b1;
      1: boot_stack_ready <= 1'b1;
      default: network_joined <= 1'b1;
    endcase
    @(posedge ref_clk);
    boot_stack_ready <= 1'b0;
    network_joined <= 1'b0;
    repeat (8) @(posedge ref_clk);
    port_b_pin_six <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : ev
  task automatic cmp_acts();
    chk(obs_q.size(), exp_q.size(), "action count");
    while (obs_q.size() > 0 && exp_q.size() > 0) chk(obs_q.pop_front(), exp_q.pop_front(), "action");
    obs_q.delete();
    exp_q.delete();
    t_q.delete();
  endtask : cmp_acts
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    eac_cfg_t cfg;
    void'($urandom(27));
    {rstn, avs_read, avs_write, port_b_pin_six, boot_stack_ready, network_joined, nv_restore_valid} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    nv_restore_data = '0;
    mdl = '{16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h8010, 16'h0000, 16'h0000};
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_all();
    wr(OFF_TMR0_THR, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      if (i != 3) wr(8'(i * 4), 16'(32'h1 | $urandom));
    end
    rd(8'h20, 32'h0000_0000);
    wr(8'h24, 16'hFFFF);
    rd_all();
    wr(OFF_STATUS, 16'h000F);
    wr(OFF_MASK, 16'h0004);
    cmp_acts();
    ev(2);
    chk(irq, 1, "irq set");
    ev(1);
    ev(1);
    ev(0);
    wr(OFF_JOIN_ACT, 16'h0000);
    ev(2);
    cmp_acts();
    rd(OFF_STATUS, 32'h7);
    wr(OFF_STATUS, 16'h0004);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0, "irq clear");
    rd(OFF_STATUS, 32'h3);
    wr(OFF_JOIN_ACT, 16'(32'h1 | $urandom));
    repeat (6) ev(2 * $urandom_range(1));
    cmp_acts();
    wr(OFF_TMR0_ACT, 16'(32'h1 | $urandom));
    wr(OFF_TMR0_THR, 16'h0002);
    repeat (60) @(posedge ref_clk);
    rd(OFF_TMR0_THR, 32'h2);
    wr(OFF_TMR0_THR, 16'h0000);
    // let an action launched by a tick in flight at the write reach the queue
    repeat (4) @(posedge ref_clk);
    chk(obs_q.size() >= 3, 1, "timer events");
    for (int i = 0; i < obs_q.size(); i++) begin
      exp_q.push_back({SRC_TMR0, mdl[4]});
      chk(obs_q[i], {SRC_TMR0, mdl[4]}, "timer action");
      if (i > 0) chk(t_q[i] - t_q[i - 1], 2 * QTR, "timer spacing");
    end
    cmp_acts();
    repeat (80) @(posedge ref_clk);
    cmp_acts();
    wr(OFF_TMR0_ACT, 16'h0000);
    wr(OFF_STATUS, 16'h000F);
    wr(OFF_TMR0_THR, 16'h0001);
    repeat (40) @(posedge ref_clk);
    wr(OFF_TMR0_THR, 16'h0000);
    cmp_acts();
    rd(OFF_STATUS, 32'h8);
    cfg = {16'(32'h1 | $urandom), 16'($urandom), 16'($urandom), 16'h0000, 16'($urandom)};
    nv_restore_data <= cfg;
    nv_restore_valid <= 1'b1;
    @(posedge ref_clk);
    nv_restore_valid <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) mdl[i] = cfg[79 - 16 * i -: 16];
    rd_all();
    rd(OFF_TMR0_CNT, 32'h0000_0000);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
endmodule : eac_bank_tb_top
